/* File: dv/test_timer_overflow_interrupt_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_timer_overflow_interrupt_control;
	logic        sys_clk, resetn, tmr_ctrl_wr, tmr_rd; // Clock, strobes
	logic        pre_lo_wr, pre_hi_wr, tmr_pin, usb_event; // Inputs
	logic        spi_done, ext_pin, gie_set, gie_clr;  // Inputs
	logic        powerdown, reti, slow, got;           // Controls
	logic [7:0]  wdata;                                // Write byte
	logic [3:0]  src_enable, flag_set, flag_clr, flags_q; // Flags
	logic        instr_boundary, tmr_run_q, take_q;    // Core, status
	logic        global_interrupt_enable_q, ret_valid_q, wake_q;
	logic [11:0] next_pc, vector_q, ret_pc_q, p;       // Addresses
	logic [15:0] count_out_q, c;                       // Counter
	logic [2:0]  sp_q;                                 // Stack depth
	int          n_mismatch, comparisons, i;           // Tallies
	toic_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .wdata(wdata),
		.tmr_ctrl_wr(tmr_ctrl_wr), .tmr_rd(tmr_rd), .pre_lo_wr(pre_lo_wr),
		.pre_hi_wr(pre_hi_wr), .tmr_pin(tmr_pin), .usb_event(usb_event),
		.spi_done(spi_done), .ext_pin(ext_pin), .src_enable(src_enable),
		.gie_set(gie_set), .gie_clr(gie_clr), .flag_set(flag_set),
		.flag_clr(flag_clr), .powerdown(powerdown), .reti(reti),
		.instr_boundary(instr_boundary), .next_pc(next_pc),
		.count_out_q(count_out_q), .tmr_run_q(tmr_run_q), .flags_q(flags_q),
		.global_interrupt_enable_q(global_interrupt_enable_q),
		.take_q(take_q), .vector_q(vector_q), .ret_valid_q(ret_valid_q),
		.ret_pc_q(ret_pc_q), .sp_q(sp_q), .wake_q(wake_q));
	toic_core_model core_u (.sys_clk(sys_clk), .resetn(resetn), .slow(slow),
		.take_q(take_q), .vector_q(vector_q), .ret_valid_q(ret_valid_q),
		.ret_pc_q(ret_pc_q), .instr_boundary(instr_boundary),
		.next_pc(next_pc));
	// 100 MHz clock
	initial
	begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Compare and tally
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Wait a bounded time for an entry; check vector and enable
	task automatic tk(input logic [11:0] v);
		got = 0;
		for (i = 0; i < 12 && !got; i++)
		begin
			cyc(1);
			got = (take_q === 1'b1);
		end
		p = next_pc;
		if (got)
		begin
			chk(vector_q, v);
			chk(global_interrupt_enable_q, 0);
		end
	endtask
	// Bounded wait for a wake pulse
	task automatic ww(input int n);
		got = 0;
		for (i = 0; i < n && !got; i++)
		begin
			cyc(1);
			got = (wake_q === 1'b1);
		end
	endtask
	task automatic gie;
		gie_set = 1;
		cyc(1);
		gie_set = 0;
	endtask
	// Single return pulse; an entry may follow at the very next edge
	task automatic ret;
		reti = 1;
		cyc(1);
		reti = 0;
	endtask
	task automatic usb;
		usb_event = 1;
		cyc(1);
		usb_event = 0;
	endtask
	// Strobe 0 preload low, 1 preload high, 2 control byte
	task automatic wr(input int s, input logic [7:0] d);
		wdata = d;
		{tmr_ctrl_wr, pre_hi_wr, pre_lo_wr} = 3'b001 << s;
		cyc(1);
		{tmr_ctrl_wr, pre_hi_wr, pre_lo_wr} = 3'b000;
		cyc(1);
	endtask
	task automatic summarize;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial
	begin
		#100000;
		n_mismatch++;
		summarize;
	end
	initial
	begin
		{tmr_ctrl_wr, tmr_rd, pre_lo_wr, pre_hi_wr, tmr_pin, resetn} = 0;
		{usb_event, spi_done, gie_set, gie_clr, powerdown, reti, slow} = 0;
		{wdata, src_enable, flag_set, flag_clr} = 0;
		ext_pin = 1;
		n_mismatch = 0;
		comparisons = 0;
		cyc(12);
		resetn = 1;
		cyc(1);
		chk(flags_q, 0);
		// Three sources while globally masked
		src_enable = 4'hF;
		{usb_event, spi_done, ext_pin} = 3'b110;
		cyc(1);
		{usb_event, spi_done} = 2'b00;
		cyc(3);
		chk(flags_q, 4'hB);
		gie;
		tk(12'h004);
		chk(flags_q, 4'hA);
		ret;
		chk(ret_pc_q, p);
		slow = 1;
		gie;
		tk(12'h008);
		ret;
		gie;
		tk(12'h010);
		ret;
		chk(flags_q, 0);
		slow = 0;
		// Masked source keeps its flag
		src_enable = 4'h0;
		usb;
		gie;
		tk(12'h004);
		chk(got, 0);
		chk(flags_q, 4'h1);
		src_enable = 4'hF;
		tk(12'h004);
		chk(got, 1);
		ret;
		// Fill the stack, then one entry is refused
		for (int k = 0; k < 6; k++)
		begin
			usb;
			gie;
			tk(12'h004);
		end
		chk(sp_q, 6);
		usb;
		gie;
		tk(12'h004);
		chk(got, 0);
		ret;
		tk(12'h004);
		chk(got, 1);
		repeat (6)
		begin
			ret;
			cyc(1);
		end
		chk(sp_q, 0);
		// Timer: preload low then high, mode before run
		src_enable = 4'h0;
		wr(0, 8'hF0);
		wr(1, 8'hFF);
		wr(2, 8'h80);
		wr(2, 8'h90);
		chk(tmr_run_q, 1);
		powerdown = 1;
		ww(120);
		chk(got, 1);
		chk(flags_q[2], 1);
		c = count_out_q;
		cyc(40);
		chk(count_out_q - c >= 9 && count_out_q - c <= 11, 1);
		tmr_rd = 1;
		cyc(2);
		c = count_out_q;
		cyc(20);
		chk(count_out_q, c);
		tmr_rd = 0;
		// Clear the flag first so that the software set is a real change
		flag_clr = 4'h4;
		cyc(1);
		flag_clr = 4'h0;
		flag_set = 4'h4;
		cyc(1);
		flag_set = 4'h0;
		ww(120);
		chk(got, 0);
		powerdown = 0;
		src_enable = 4'h4;
		gie;
		tk(12'h00C);
		ret;
		wr(2, 8'h80);
		chk(tmr_run_q, 0);
		// Event mode: count three rising pin edges from zero
		wr(2, 8'h40);
		wr(0, 8'h00);
		wr(1, 8'h00);
		wr(2, 8'h50);
		repeat (3)
		begin
			tmr_pin = 1;
			cyc(8);
			tmr_pin = 0;
			cyc(8);
		end
		chk(count_out_q, 3);
		// Pulse mode: count while pin is high, then stop by itself
		wr(2, 8'hC8);
		wr(0, 8'h00);
		wr(1, 8'h00);
		wr(2, 8'hD8);
		tmr_pin = 1;
		cyc(40);
		tmr_pin = 0;
		cyc(16);
		chk(tmr_run_q, 0);
		chk(count_out_q >= 9 && count_out_q <= 11, 1);
		summarize;
	end
endmodule
`default_nettype wire

/* File: dv/toic_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module toic_core_model
(
	input wire logic        sys_clk,        // Clock
	input wire logic        resetn,         // Reset, active low
	input wire logic        slow,           // Two-cycle instructions
	input wire logic        take_q,         // Entry pulse
	input wire logic [11:0] vector_q,       // Entry vector
	input wire logic        ret_valid_q,    // Return valid
	input wire logic [11:0] ret_pc_q,       // Return address
	output logic            instr_boundary, // At boundary
	output logic [11:0]     next_pc         // Next fetch address
);
	logic ph_q; // Boundary phase
	// Jump on entry, resume on return; slow gives late boundaries
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ph_q <= 1'b0;
			next_pc <= 12'h020;
		end
		else
		begin
			ph_q <= slow ? ~ph_q : 1'b1;
			if (take_q)
				next_pc <= vector_q;
			else if (ret_valid_q)
				next_pc <= ret_pc_q;
		end
	end
	assign instr_boundary = ph_q;
endmodule
`default_nettype wire

/* File: dv/toic_top_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module toic_checker
(
	input wire logic        sys_clk,        // Clock
	input wire logic        resetn,         // Reset, active low
	input wire logic        usb_event,      // USB event
	input wire logic        ext_pin,        // External pin
	input wire logic [3:0]  src_enable,     // Source enables
	input wire logic        powerdown,      // Power-down
	input wire logic        instr_boundary, // Boundary
	input wire logic        reti,           // Return pulse
	input wire logic [3:0]  flag_set,       // Software flag sets
	input wire logic [3:0]  flags_q,        // Request flags
	input wire logic        global_interrupt_enable_q, // Global enable
	input wire logic        take_q,         // Entry pulse
	input wire logic [11:0] vector_q,       // Entry vector
	input wire logic        ret_valid_q,    // Return valid
	input wire logic [2:0]  sp_q,           // Stack depth
	input wire logic        wake_q          // Wake pulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic [11:0] exp_q; // Vector of best pending source
	// Highest enabled pending source, seen at the accept edge
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			exp_q <= 12'h000;
		else if (flags_q[0] && src_enable[0])
			exp_q <= 12'h004;
		else if (flags_q[1] && src_enable[1])
			exp_q <= 12'h008;
		else if (flags_q[2] && src_enable[2])
			exp_q <= 12'h00C;
		else
			exp_q <= 12'h010;
	end
	// All entry conditions met at one edge
	sequence s_offer;
		instr_boundary && global_interrupt_enable_q && sp_q != 3'h6
			&& (flags_q & src_enable) != 4'h0;
	endsequence
	a_take_offer: assert property (s_offer |=> take_q)
		else $error("entry not taken");
	a_take_cause: assert property (take_q |->
		$past(global_interrupt_enable_q && instr_boundary))
		else $error("entry without enable");
	a_gie_cleared: assert property (take_q |-> !global_interrupt_enable_q)
		else $error("global enable kept");
	a_push_count: assert property (take_q |-> sp_q == $past(sp_q) + 3'h1)
		else $error("stack not pushed");
	a_full_hold: assert property (sp_q == 3'h6 |=> !take_q)
		else $error("entry on full stack");
	a_vector_prio: assert property (take_q |-> vector_q == exp_q)
		else $error("wrong vector");
	a_ext_edge: assert property ($fell(ext_pin) |-> ##[1:3] flags_q[1])
		else $error("pin edge lost");
	a_usb_flag: assert property (usb_event |=> flags_q[0])
		else $error("event flag lost");
	a_ret_pop: assert property (ret_valid_q |->
		$past(reti) && sp_q == $past(sp_q) - 3'h1)
		else $error("return not popped");
	// Only a rise caused by an overflow must wake; software sets do not
	a_wake_ovf: assert property ($rose(flags_q[2]) && $past(powerdown)
		&& !$past(flag_set[2]) |-> ##[0:2] wake_q)
		else $error("no wake");
endmodule
bind toic_top toic_checker u_chk (.sys_clk(sys_clk), .resetn(resetn),
	.usb_event(usb_event), .ext_pin(ext_pin), .src_enable(src_enable),
	.powerdown(powerdown), .instr_boundary(instr_boundary), .reti(reti),
	.flag_set(flag_set),
	.flags_q(flags_q), .take_q(take_q), .vector_q(vector_q),
	.global_interrupt_enable_q(global_interrupt_enable_q),
	.ret_valid_q(ret_valid_q), .sp_q(sp_q), .wake_q(wake_q));
`default_nettype wire

/* File: hw/toic_map.vh */
`ifndef TOIC_MAP_VH
`define TOIC_MAP_VH
// Timer control byte fields
`define TOIC_MODE_HI        7
`define TOIC_MODE_LO        6
`define TOIC_RUN_BIT        4
`define TOIC_EDGE_BIT       3
// Timer modes (bits 7:6)
`define TOIC_MODE_EVENT     2'h1
`define TOIC_MODE_TIMER     2'h2
`define TOIC_MODE_PULSE     2'h3
// Instruction clock divider
`define TOIC_CLK_DIV        4
`define TOIC_DIV_MAX        2'h3
// Interrupt vectors
`define TOIC_VEC_USB        12'h004
`define TOIC_VEC_EXT        12'h008
`define TOIC_VEC_TMR        12'h00C
`define TOIC_VEC_SPI        12'h010
// Source indices, highest priority first
`define TOIC_SRC_USB        0
`define TOIC_SRC_EXT        1
`define TOIC_SRC_TMR        2
`define TOIC_SRC_SPI        3
// Stack
`define TOIC_STACK_DEPTH    6
`define TOIC_SP_FULL        3'h6
// Reset values
`define TOIC_CTRL_RST       8'h00
`define TOIC_CNT_RST        16'h0000
`endif

/* File: hw/toic_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "toic_map.vh"
// Timer/event counter with preload, run control and overflow pulse
module toic_timer
(
	input  wire        sys_clk,     // System clock
	input  wire        resetn,      // Async reset, active low
	input  wire        tick,        // Instruction clock pulse
	input  wire [7:0]  ctrl,        // Timer control byte
	input  wire        ctrl_wr,     // Control byte write strobe
	input  wire        pin,         // External timer pin
	input  wire        rd,          // Counter read strobe
	input  wire        pre_lo_wr,   // Preload low write strobe
	input  wire        pre_hi_wr,   // Preload high write strobe
	input  wire [7:0]  wdata,       // Write data
	output reg  [15:0] count_q,     // Counter value
	output reg         run_q,       // Run bit state
	output reg         ovf_q        // Overflow pulse
);
	reg [15:0] pre_q;     // Preload value
	reg        pin_q;     // Pin sampled on tick
	reg        pin_old_q; // Previous tick sample
	wire [1:0] mode;
	wire       edge_hi;
	wire       inhibit;
	wire       active;
	wire       inc;
	assign mode    = ctrl[`TOIC_MODE_HI:`TOIC_MODE_LO];
	assign edge_hi = ctrl[`TOIC_EDGE_BIT];
	// Clock is inhibited during reads and preload writes
	assign inhibit = rd | pre_lo_wr | pre_hi_wr; // R3
	// Pulse mode counts while pin sits at the active level
	assign active  = edge_hi ? pin_q : ~pin_q;
	// Increment decision uses the tick-aligned samples only
	assign inc = run_q & tick & ~inhibit & // R1 R2
		((mode == `TOIC_MODE_TIMER) |
		 (mode == `TOIC_MODE_PULSE & active) |
		 (mode == `TOIC_MODE_EVENT &
		  (edge_hi ? (pin_old_q & ~pin_q) : (~pin_old_q & pin_q))));
	// Pin is taken only on a timer clock pulse
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_q     <= 1'b0;
			pin_old_q <= 1'b0;
		end
		else if (tick) // R2
		begin
			pin_q     <= pin;
			pin_old_q <= pin_q;
		end
	end
	// Run bit: software write, auto stop at pulse end
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			run_q <= 1'b0;
		else if (ctrl_wr)
			run_q <= wdata[`TOIC_RUN_BIT]; // R6
		else if (run_q & tick & mode == `TOIC_MODE_PULSE & pin_old_q != pin_q
			& !active)
			run_q <= 1'b0;
	end
	// Preload, counter and overflow reload
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pre_q   <= `TOIC_CNT_RST;
			count_q <= `TOIC_CNT_RST;
			ovf_q   <= 1'b0;
		end
		else
		begin
			ovf_q <= 1'b0;
			if (pre_lo_wr)
				pre_q[7:0] <= wdata;
			if (pre_hi_wr)
			begin
				// High byte write also loads the counter
				pre_q[15:8] <= wdata;
				count_q     <= {wdata, pre_q[7:0]};
			end
			else if (inc)
			begin
				if (count_q == 16'hFFFF)
				begin
					count_q <= pre_q;
					ovf_q   <= 1'b1;
				end
				else
					count_q <= count_q + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

/* File: hw/toic_top.v */
// Contract
// R1: Timer mode counts instruction clock, sysclk/4
// R2: External pin acts on next timer tick
// R3: Counter read or preload write inhibits clock
// R4: Software preloads counter before starting
// R5: Software sets run after mode bits
// R6: Run bit is control bit 4
// R7: Software writes preload low byte first
// R8: Overflow sets flag; interrupt needs enable
// R9: Overflow wakes powerdown regardless of enable
// R10: Preset flag blocks wake; only new set
// R11: Vectors USB 04, ext 08, timer 0C, SPI 10
// R12: Four events each set own flag
// R13: Per-source enables; flags set regardless
// R14: Global enable zero blocks all service
// R15: Service pushes return PC, loads vector
// R16: Return pops saved PC
// R17: Service entry clears global enable
// R18: Blocked requests stay latched for later
// R19: Nesting routine re-sets global enable
// R20: Full stack refuses acknowledgement
// R21: Priority USB, ext, timer, SPI
// R22: Servicing clears that source flag
// R23: External flag set on falling pin edge
// R24: Flags hold until serviced or cleared
// R25: Accept only at instruction boundary
`timescale 1ns/1ps
`default_nettype none
`include "toic_map.vh"
module toic_top
(
	input  wire        sys_clk,         // System clock, 100 MHz
	input  wire        resetn,          // Async reset, active low
	input  wire        tmr_ctrl_wr,     // Timer control byte write
	input  wire        tmr_rd,          // Counter read strobe
	input  wire        pre_lo_wr,       // Preload low byte write
	input  wire        pre_hi_wr,       // Preload high byte write
	input  wire [7:0]  wdata,           // Write data byte
	input  wire        tmr_pin,         // External timer pin
	input  wire        usb_event,       // USB event pulse
	input  wire        spi_done,        // SPI byte complete pulse
	input  wire        ext_pin,         // External interrupt pin
	input  wire [3:0]  src_enable,      // Per-source enables
	input  wire        gie_set,         // Software sets global enable
	input  wire        gie_clr,         // Software clears global enable
	input  wire [3:0]  flag_set,        // Software sets flags
	input  wire [3:0]  flag_clr,        // Software clears flags
	input  wire        powerdown,       // Core in power-down
	input  wire        instr_boundary,  // Core at instruction boundary
	input  wire [11:0] next_pc,         // Address of next instruction
	input  wire        reti,            // Return-from-interrupt pulse
	output reg  [15:0] count_out_q,     // Counter value
	output reg         tmr_run_q,       // Timer run state
	output reg  [3:0]  flags_q,         // Request flags
	output reg         global_interrupt_enable_q, // Global enable
	output reg         take_q,          // Interrupt taken pulse
	output reg  [11:0] vector_q,        // Vector for fetch
	output reg         ret_valid_q,     // Return address valid pulse
	output reg  [11:0] ret_pc_q,        // Popped return address
	output reg  [2:0]  sp_q,            // Stack depth in use
	output reg         wake_q           // Wake-up pulse
);
	reg  [1:0]  div_q;        // Instruction clock divider
	reg         tick_q;       // Instruction clock pulse
	reg  [7:0]  ctrl_q;       // Timer control byte
	reg         ext_old_q;    // Previous ext pin level
	reg  [11:0] stack_q [0:`TOIC_STACK_DEPTH-1]; // Return stack
	wire [15:0] count;
	wire        run;
	wire        ovf;
	wire [3:0]  events;
	wire [3:0]  pend;
	reg  [3:0]  sel;
	reg  [11:0] vec;
	wire        accept;
	genvar      g;

	// Divide system clock by four for the instruction clock
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			div_q  <= 2'h0;
			tick_q <= 1'b0;
		end
		else
		begin
			div_q  <= div_q + 2'h1;
			tick_q <= (div_q == `TOIC_DIV_MAX); // R1
		end
	end

	// Control byte register
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			ctrl_q <= `TOIC_CTRL_RST;
		else if (tmr_ctrl_wr)
			ctrl_q <= wdata;
	end

	toic_timer u_timer
	(
		.sys_clk     (sys_clk),
		.resetn      (resetn),
		.tick        (tick_q),
		.ctrl        (ctrl_q),
		.ctrl_wr     (tmr_ctrl_wr),
		.pin         (tmr_pin),
		.rd          (tmr_rd),
		.pre_lo_wr   (pre_lo_wr),
		.pre_hi_wr   (pre_hi_wr),
		.wdata       (wdata),
		.count_q     (count),
		.run_q       (run),
		.ovf_q       (ovf)
	);

	// Mirror timer state onto registered outputs
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			count_out_q <= `TOIC_CNT_RST;
			tmr_run_q   <= 1'b0;
		end
		else
		begin
			count_out_q <= count;
			tmr_run_q   <= run;
		end
	end

	// External pin falling edge detector
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			ext_old_q <= 1'b1;
		else
			ext_old_q <= ext_pin;
	end

	// Source events in priority order
	assign events[`TOIC_SRC_USB] = usb_event;              // R12
	assign events[`TOIC_SRC_EXT] = ext_old_q & ~ext_pin;   // R23
	assign events[`TOIC_SRC_TMR] = ovf;                    // R8
	assign events[`TOIC_SRC_SPI] = spi_done;               // R12

	// Service allowed: boundary, global enable, stack not full
	assign pend   = flags_q & src_enable;                  // R13
	assign accept = instr_boundary & global_interrupt_enable_q & // R25 R14
		(|pend) & (sp_q != `TOIC_SP_FULL);             // R20

	// Fixed priority select and vector
	always @*
	begin
		sel = 4'h0;
		vec = `TOIC_VEC_USB;
		if (pend[`TOIC_SRC_USB]) // R21
		begin
			sel = 4'h1;
			vec = `TOIC_VEC_USB; // R11
		end
		else if (pend[`TOIC_SRC_EXT])
		begin
			sel = 4'h2;
			vec = `TOIC_VEC_EXT;
		end
		else if (pend[`TOIC_SRC_TMR])
		begin
			sel = 4'h4;
			vec = `TOIC_VEC_TMR;
		end
		else if (pend[`TOIC_SRC_SPI])
		begin
			sel = 4'h8;
			vec = `TOIC_VEC_SPI;
		end
	end

	// Per-source sticky flags; a new event beats any clear
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : flag_gen
			always @(posedge sys_clk or negedge resetn)
			begin
				if (!resetn)
					flags_q[g] <= 1'b0;
				else if (events[g] | flag_set[g]) // R12 R18
					flags_q[g] <= 1'b1;
				else if ((accept & sel[g]) | flag_clr[g]) // R22 R24
					flags_q[g] <= 1'b0;
			end
		end
	endgenerate

	// Global enable: entry clears it, software sets it again
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			global_interrupt_enable_q <= 1'b0;
		else if (accept)
			global_interrupt_enable_q <= 1'b0; // R17
		else if (gie_set)
			global_interrupt_enable_q <= 1'b1; // R19
		else if (gie_clr)
			global_interrupt_enable_q <= 1'b0;
	end

	// Stack push on entry, pop on return
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sp_q        <= 3'h0;
			take_q      <= 1'b0;
			vector_q    <= 12'h000;
			ret_valid_q <= 1'b0;
			ret_pc_q    <= 12'h000;
		end
		else
		begin
			take_q      <= accept;
			ret_valid_q <= 1'b0;
			if (accept)
			begin
				stack_q[sp_q] <= next_pc; // R15
				sp_q          <= sp_q + 3'h1;
				vector_q      <= vec;
			end
			else if (reti & sp_q != 3'h0)
			begin
				ret_pc_q    <= stack_q[sp_q - 3'h1]; // R16
				ret_valid_q <= 1'b1;
				sp_q        <= sp_q - 3'h1;
			end
		end
	end

	// Wake on a new timer overflow, independent of enables
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			wake_q <= 1'b0;
		else
			wake_q <= powerdown & ovf & ~flags_q[`TOIC_SRC_TMR]; // R9 R10
	end
endmodule
`default_nettype wire
